// [common/fsf_consts.vh]
// Purpose: Constants shared by the status-flag buffer design files.
// Assumes: Included by bare name; definitions only.
// Notes:   Depth choices and default flag offsets follow the supported organisations.
`ifndef FSF_CONSTS_VH
`define FSF_CONSTS_VH

// ****************************************
// Data path
// ****************************************
`define FSF_DATA_W        18
`define FSF_DATA_RST      18'h00000

// ****************************************
// Depth choices
// ****************************************
`define FSF_DEPTH_256     256
`define FSF_DEPTH_512     512
`define FSF_DEPTH_1K      1024
`define FSF_DEPTH_2K      2048
`define FSF_DEPTH_4K      4096
`define FSF_DEPTH_DEF     1024

// ****************************************
// Default flag offsets after reset
// ****************************************
`define FSF_OFF_SMALL     31
`define FSF_OFF_MID       63
`define FSF_OFF_LARGE     127

// ****************************************
// Flag levels (all indications are active low)
// ****************************************
`define FSF_ACT           1'b0
`define FSF_IDLE          1'b1

`endif

// [dv/fsf_partner.sv]
// Purpose: Writer and reader logic facing the buffer.
// Assumes: Enables follow the registered flags, so they change just after an edge.
// Notes:   rude_i ignores the flags, only where a scenario wants a refusal.
`default_nettype none
module fsf_partner (
  // Requests from the bench
  input wire logic  want_wr_i,
  input wire logic  want_rd_i,
  input wire logic  rude_i,
  // Flags from the buffer
  input wire logic  full_ind_n_i,
  input wire logic  empty_ind_n_i,
  // Enables toward the buffer
  output var logic  wr_en_n_o,
  output var logic  rd_en_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign wr_en_n_o = !(want_wr_i && (full_ind_n_i || rude_i));
  assign rd_en_n_o = !(want_rd_i && (empty_ind_n_i || rude_i));
endmodule // fsf_partner
`default_nettype wire

// [dv/fsf_properties.sv]
// Purpose: Flag and chain-pulse properties of the status-flag buffer.
// Assumes: One clock domain; synchronous active-low reset.
// Notes:   Offsets are the fixed reset defaults; mode changes only in reset.
`default_nettype none
`include "fsf_consts.vh"
module fsf_properties #(
  parameter int DEPTH = `FSF_DEPTH_DEF
) (
  // Clock, reset and enables
  input wire logic                   core_clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   wr_en_n_i,
  input wire logic                   rd_en_n_i,
  input wire logic                   expand_mode_i,
  // Data and flags
  input wire logic [`FSF_DATA_W-1:0] dout_o,
  input wire logic                   empty_ind_n_o,
  input wire logic                   almost_empty_n_o,
  input wire logic                   almost_full_n_o,
  input wire logic                   full_ind_n_o,
  input wire logic                   half_full_wr_chain_out_n_o,
  input wire logic                   rd_chain_out_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ****************************************
  // Properties
  // ****************************************
  AST_RD_BLOCKED: assert property (!empty_ind_n_o && wr_en_n_i |=> !empty_ind_n_o && $stable(dout_o))
    else $error("read taken or data moved while empty");
  AST_WR_BLOCKED: assert property (!full_ind_n_o && rd_en_n_i |=> !full_ind_n_o)
    else $error("write taken while full");
  AST_EMPTY_LEAVES: assert property (!empty_ind_n_o && !wr_en_n_i && !expand_mode_i |=> empty_ind_n_o)
    else $error("write did not clear empty");
  AST_FULL_LEAVES: assert property (!full_ind_n_o && !rd_en_n_i && !expand_mode_i |=> full_ind_n_o)
    else $error("read did not clear full");
  AST_AE_AT_EMPTY: assert property (!empty_ind_n_o |-> !almost_empty_n_o)
    else $error("almost empty high while empty");
  AST_AF_AT_FULL: assert property (!full_ind_n_o |-> !almost_full_n_o)
    else $error("almost full high while full");
  AST_HALF_ENDS: assert property (!expand_mode_i |-> (full_ind_n_o || !half_full_wr_chain_out_n_o) &&
    (empty_ind_n_o || half_full_wr_chain_out_n_o)) else $error("half full wrong at an end");
  AST_WCHAIN_PULSE: assert property (expand_mode_i && !half_full_wr_chain_out_n_o |=> half_full_wr_chain_out_n_o)
    else $error("write chain pulse longer than one cycle");
  AST_RCHAIN_PULSE: assert property (expand_mode_i && !rd_chain_out_n_o |=> rd_chain_out_n_o)
    else $error("read chain pulse longer than one cycle");
  AST_RCHAIN_IDLE: assert property (!expand_mode_i |-> rd_chain_out_n_o)
    else $error("read chain pulsed outside expansion");
  AST_RESET_FLAGS: assert property (disable iff (1'b0) !rst_b_i |=> !empty_ind_n_o && !almost_empty_n_o &&
    full_ind_n_o && almost_full_n_o) else $error("flags wrong after reset");
  COV_FULL: cover property (!full_ind_n_o);
  COV_WCHAIN: cover property (expand_mode_i && !half_full_wr_chain_out_n_o);
  COV_RCHAIN: cover property (expand_mode_i && !rd_chain_out_n_o);
endmodule // fsf_properties
bind fsf_top fsf_properties #(.DEPTH(DEPTH)) fsf_properties_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wr_en_n_i(wr_en_n_i), .rd_en_n_i(rd_en_n_i),
  .expand_mode_i(expand_mode_i), .dout_o(dout_o), .empty_ind_n_o(empty_ind_n_o),
  .almost_empty_n_o(almost_empty_n_o), .almost_full_n_o(almost_full_n_o), .full_ind_n_o(full_ind_n_o),
  .half_full_wr_chain_out_n_o(half_full_wr_chain_out_n_o), .rd_chain_out_n_o(rd_chain_out_n_o)
);
`default_nettype wire

// [dv/fsf_top_tb_top.sv]
// Purpose: Self-checking bench for the status-flag buffer.
// Assumes: Depth 256, so offsets are the smallest default.
// Notes:   A queue model predicts every flag after every edge that cyc drives.
`default_nettype none
`include "fsf_consts.vh"
module fsf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = `FSF_DEPTH_256;
  localparam int OFF   = `FSF_OFF_SMALL;
  logic                   core_clk_i, rst_b_i, want_wr, want_rd, rude, expand, chain_n, first_n;
  logic [`FSF_DATA_W-1:0] din, exp_dout, q[$];
  wire  [`FSF_DATA_W-1:0] dout;
  wire                    we_n, re_n, e_n, ae_n, af_n, f_n, hf_n, rxo_n;
  int                     mismatches, checked, wp, rp;
  bit                     wtok, rtok;
  fsf_top #(.DEPTH(DEPTH)) fsf_top_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .din_i(din), .wr_en_n_i(we_n), .rd_en_n_i(re_n),
    .dout_o(dout), .expand_mode_i(expand), .first_in_chain_n_i(first_n), .wr_chain_in_n_i(chain_n),
    .rd_chain_in_n_i(chain_n), .empty_ind_n_o(e_n), .almost_empty_n_o(ae_n), .almost_full_n_o(af_n),
    .full_ind_n_o(f_n), .half_full_wr_chain_out_n_o(hf_n), .rd_chain_out_n_o(rxo_n));
  fsf_partner fsf_partner_i (.want_wr_i(want_wr), .want_rd_i(want_rd), .rude_i(rude),
    .full_ind_n_i(f_n), .empty_ind_n_i(e_n), .wr_en_n_o(we_n), .rd_en_n_o(re_n));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ****************************************
  // Compare, drive and scenario tasks
  // ****************************************
  task automatic cmp_flag(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic cmp_word(input string nm, input logic [17:0] exp, input logic [17:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One cycle: drive at the falling edge, predict at the rising one, judge just after
  task automatic cyc(input logic w, input logic r, input logic rd, input logic ch, input logic [17:0] d);
    bit aw, ar, wpl, rpl;
    @(negedge core_clk_i);
    want_wr = w;
    want_rd = r;
    rude = rd;
    chain_n = !ch;
    din = d;
    @(posedge core_clk_i);
    aw = !we_n && q.size() < DEPTH && wtok;
    ar = !re_n && q.size() > 0 && rtok;
    wpl = aw && wp == DEPTH - 1;
    rpl = ar && rp == DEPTH - 1;
    if (ar) exp_dout = q.pop_front();
    if (aw) q.push_back(d);
    wp = aw ? (wp + 1) % DEPTH : wp;
    rp = ar ? (rp + 1) % DEPTH : rp;
    wtok = expand ? (!wpl && (wtok || ch)) : 1'b1;
    rtok = expand ? (!rpl && (rtok || ch)) : 1'b1;
    #1;
    cmp_flag("empty", q.size() != 0, e_n);
    cmp_flag("almost_empty", q.size() > OFF, ae_n);
    cmp_flag("almost_full", q.size() < DEPTH - OFF, af_n);
    cmp_flag("full", q.size() != DEPTH, f_n);
    cmp_flag("half_chain", expand ? !wpl : q.size() <= DEPTH / 2, hf_n);
    cmp_flag("rd_chain", !(expand && rpl), rxo_n);
    cmp_word("dout", exp_dout, dout);
  endtask
  // Requests drop with reset, so the unwatched edge after release takes nothing
  task automatic do_reset(input logic ex, input logic fst_n);
    @(negedge core_clk_i);
    rst_b_i = 1'b0;
    expand = ex;
    first_n = fst_n;
    {want_wr, want_rd, rude} = 3'h0;
    repeat (12) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    q.delete();
    {wp, rp, exp_dout} = {32'h0, 32'h0, 18'h00000};
    wtok = !ex || !fst_n;
    rtok = !ex || !fst_n;
  endtask
  // Fill past full with refused writes, then drain past empty with a refused read
  task automatic sc_fill_drain(input logic ex);
    do_reset(ex, 1'b0);
    cyc(0, 0, 0, 0, 18'h00000);
    for (int i = 0; i < DEPTH; i++) cyc(1, 0, 0, 0, 18'h2a5a5 ^ i[17:0]);
    cyc(1, 0, 1, 0, 18'h3ffff);
    cyc(1, 0, 0, 0, 18'h3fffe);
    for (int i = 0; i < DEPTH; i++) cyc(0, 1, 0, 0, 18'h00000);
    cyc(0, 1, 1, 0, 18'h00000);
  endtask
  // Back-to-back simultaneous traffic keeps the fill steady
  task automatic sc_both();
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 40; i++) cyc(1, i > 4, 0, 0, 18'h15000 + i[17:0]);
  endtask
  // Expansion turn handed back by the chain inputs
  task automatic sc_turn();
    cyc(1, 0, 0, 0, 18'h01234);
    cyc(0, 0, 0, 1, 18'h00000);
    cyc(1, 0, 0, 0, 18'h04321);
    cyc(0, 1, 0, 0, 18'h00000);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_b_i, expand, want_wr, want_rd, rude, chain_n, first_n, din} = {7'b0000010, 18'h00000};
    sc_fill_drain(0);
    sc_both();
    sc_fill_drain(1);
    sc_turn();
    // A later device of the chain starts without either turn
    do_reset(1'b1, 1'b1);
    sc_turn();
    print_verdict();
  end
  // Whole run is near 1130 cycles; the 5200-cycle limit, over four times that, means a hang
  initial begin
    #26000;
    mismatches++;
    print_verdict();
  end
endmodule // fsf_top_tb_top
`default_nettype wire

// [hw/fsf_mem.v]
// Purpose: Storage array with one write port and a registered read port.
// Assumes: Single clock; caller only reads or writes legal locations.
// Notes:   Read data register holds while no read is taken.
`default_nettype none
`include "fsf_consts.vh"

module fsf_mem #(
  parameter DEPTH = `FSF_DEPTH_DEF,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_b_i,
  // Write port
  input  wire                   we_i,
  input  wire [AW-1:0]          waddr_i,
  input  wire [`FSF_DATA_W-1:0] wdata_i,
  // Read port
  input  wire                   re_i,
  input  wire [AW-1:0]          raddr_i,
  output reg  [`FSF_DATA_W-1:0] rdata_o
);

  reg [`FSF_DATA_W-1:0] store [0:DEPTH-1];

  always @(posedge core_clk_i) begin
    if (we_i) begin
      store[waddr_i] <= wdata_i;
    end
  end

  // Output register only advances on an accepted read
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= `FSF_DATA_RST;
    end else if (re_i) begin
      rdata_o <= store[raddr_i];
    end
  end

endmodule // fsf_mem

`default_nettype wire

// [hw/fsf_top.v]
// Purpose: Clocked 18-bit buffer with empty, full, almost and half-full flags
//          and daisy-chain expansion pulses.
// Assumes: Writer and reader share core_clk_i; all inputs synchronous to it.
// Notes:   Flag offsets are fixed at their reset defaults; no load sequence.
//
// Behaviour
// - Empty flag low while no word is stored; reads then blocked.
// - Empty flag changes only on rising clock edges.
// - Almost-empty low when fill is within offset of empty; default 31/63/127.
// - Almost-full low when free space within offset of full; same defaults.
// - Full flag low when every location is used; writes then ignored.
// - Full flag changes only on rising clock edges.
// - Without depth expansion, shared output is low when more than half full.
// - With depth expansion, write of last location pulses the write chain out.
// - With depth expansion, read of last location pulses the read chain out.
// - Read words appear on an 18-bit output bus.
// - Reset clears pointers, full flags high, empty flags low.
// - Low write enable stores data each edge unless full or, with depth expansion, the write turn is not held.
// - Low read enable advances each edge unless empty or, with depth expansion, the read turn is not held; else output holds.
`default_nettype none
`include "fsf_consts.vh"

module fsf_top #(
  parameter DEPTH = `FSF_DEPTH_DEF
) (
  // Clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_b_i,
  // Write side
  input  wire [`FSF_DATA_W-1:0] din_i,
  input  wire                   wr_en_n_i,
  // Read side
  input  wire                   rd_en_n_i,
  output wire [`FSF_DATA_W-1:0] dout_o,
  // Expansion configuration
  input  wire                   expand_mode_i,
  input  wire                   first_in_chain_n_i,
  input  wire                   wr_chain_in_n_i,
  input  wire                   rd_chain_in_n_i,
  // Status flags
  output reg                    empty_ind_n_o,
  output reg                    almost_empty_n_o,
  output reg                    almost_full_n_o,
  output reg                    full_ind_n_o,
  output reg                    half_full_wr_chain_out_n_o,
  output reg                    rd_chain_out_n_o
);

  // ****************************************
  // Derived sizes
  // ****************************************
  function integer fsf_clog2;
    input integer val;
    integer       v;
    begin
      v = val - 1;
      fsf_clog2 = 0;
      while (v > 0) begin
        fsf_clog2 = fsf_clog2 + 1;
        v = v >> 1;
      end
    end
  endfunction

  localparam AW = fsf_clog2(DEPTH);
  localparam CW = AW + 1;

  // Offset groups by depth
  localparam integer OFF_DEF = (DEPTH == `FSF_DEPTH_256) ? `FSF_OFF_SMALL :
                               (DEPTH == `FSF_DEPTH_512) ? `FSF_OFF_MID :
                               `FSF_OFF_LARGE;

  localparam [CW-1:0] DEPTH_C   = DEPTH[CW-1:0];
  localparam [CW-1:0] HALF_C    = DEPTH_C >> 1;
  localparam [CW-1:0] AE_LIM    = OFF_DEF[CW-1:0];
  localparam [CW-1:0] AF_LIM    = DEPTH_C - OFF_DEF[CW-1:0];
  localparam [AW-1:0] LAST_ADDR = DEPTH_C[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
  localparam [AW-1:0] ADDR_ZERO = {AW{1'b0}};
  localparam [AW-1:0] ADDR_ONE  = {{(AW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] CNT_ZERO  = {CW{1'b0}};
  localparam [CW-1:0] CNT_ONE   = {{(CW-1){1'b0}}, 1'b1};

  // ****************************************
  // State
  // ****************************************
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [CW-1:0] fill;
  reg           wr_token;
  reg           rd_token;

  reg  [CW-1:0] next_fill;
  wire          wr_ok;
  wire          rd_ok;
  wire          wr_last;
  wire          rd_last;

  // Gates use the registered flags, so a request in the cycle the
  // buffer fills or drains is dropped rather than overrunning.
  assign wr_ok = !wr_en_n_i && full_ind_n_o && wr_token;
  assign rd_ok = !rd_en_n_i && empty_ind_n_o && rd_token;

  assign wr_last = wr_ok && (wr_ptr == LAST_ADDR);
  assign rd_last = rd_ok && (rd_ptr == LAST_ADDR);

  // ****************************************
  // Fill level
  // ****************************************
  always @* begin
    next_fill = fill;
    if (wr_ok && !rd_ok) begin
      next_fill = fill + CNT_ONE;
    end else if (rd_ok && !wr_ok) begin
      next_fill = fill - CNT_ONE;
    end
  end

  // ****************************************
  // Pointers and fill register
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= ADDR_ZERO;
      rd_ptr <= ADDR_ZERO;
      fill   <= CNT_ZERO;
    end else begin
      fill <= next_fill;
      if (wr_ok) begin
        wr_ptr <= wr_last ? ADDR_ZERO : wr_ptr + ADDR_ONE;
      end
      if (rd_ok) begin
        rd_ptr <= rd_last ? ADDR_ZERO : rd_ptr + ADDR_ONE;
      end
    end
  end

  // ****************************************
  // Chain tokens
  // ****************************************
  // A device holds the write (read) turn until it uses its last location,
  // then hands it on; the chain input hands it back. Outside depth
  // expansion the turn is always held.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wr_token <= !expand_mode_i || !first_in_chain_n_i;
      rd_token <= !expand_mode_i || !first_in_chain_n_i;
    end else if (!expand_mode_i) begin
      wr_token <= 1'b1;
      rd_token <= 1'b1;
    end else begin
      if (wr_last) begin
        wr_token <= 1'b0;
      end else if (!wr_chain_in_n_i) begin
        wr_token <= 1'b1;
      end
      if (rd_last) begin
        rd_token <= 1'b0;
      end else if (!rd_chain_in_n_i) begin
        rd_token <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Flags are registered from the next fill level, so they change on
  // the same edge as the fill and never glitch between edges.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      empty_ind_n_o              <= `FSF_ACT;
      almost_empty_n_o           <= `FSF_ACT;
      almost_full_n_o            <= `FSF_IDLE;
      full_ind_n_o               <= `FSF_IDLE;
      half_full_wr_chain_out_n_o <= `FSF_IDLE;
      rd_chain_out_n_o           <= `FSF_IDLE;
    end else begin
      empty_ind_n_o    <= (next_fill == CNT_ZERO) ? `FSF_ACT : `FSF_IDLE;
      almost_empty_n_o <= (next_fill <= AE_LIM) ? `FSF_ACT : `FSF_IDLE;
      almost_full_n_o  <= (next_fill >= AF_LIM) ? `FSF_ACT : `FSF_IDLE;
      full_ind_n_o     <= (next_fill == DEPTH_C) ? `FSF_ACT : `FSF_IDLE;
      if (expand_mode_i) begin
        half_full_wr_chain_out_n_o <= wr_last ? `FSF_ACT : `FSF_IDLE;
        rd_chain_out_n_o           <= rd_last ? `FSF_ACT : `FSF_IDLE;
      end else begin
        half_full_wr_chain_out_n_o <= (next_fill > HALF_C) ? `FSF_ACT : `FSF_IDLE;
        rd_chain_out_n_o           <= `FSF_IDLE;
      end
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  fsf_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_ok),
    .waddr_i    (wr_ptr),
    .wdata_i    (din_i),
    .re_i       (rd_ok),
    .raddr_i    (rd_ptr),
    .rdata_o    (dout_o)
  );

endmodule // fsf_top

`default_nettype wire
